/* File: core/btae_code_map.sv */
/*
  Combinational transfer-code map: turns an operation kind, its source
  and the first-try flag into write-through level and transfer code.
  Assumes inputs are stable while the address tenure is presented.
*/
`timescale 1ns/1ps
module btae_code_map
  import btae_pkg::*;
(
  input wire logic [2:0] op_kind,
  input wire logic from_cbb,
  input wire logic first_try,
  output logic wt_level,
  output logic [2:0] code
);
  // first presentation of a copy-back write is sent in ambiguous form
  wire ambiguous = from_cbb && first_try &&
    (op_kind == BTAE_OP_CASTOUT || op_kind == BTAE_OP_CLEAN ||
     op_kind == BTAE_OP_FLUSH);
  // wt_level is the raw pin level: 0 means the active-low pin asserted
  assign wt_level = ambiguous ? 1'b0 :                   // [R7] [R8]
    (op_kind == BTAE_OP_CASTOUT) ? 1'b1 : 1'b0;
  assign code =
    ambiguous ? BTAE_TC_000 :                            // [R8]
    (op_kind == BTAE_OP_CASTOUT) ? BTAE_TC_100 :         // [R6]
    (op_kind == BTAE_OP_FLUSH) ? BTAE_TC_100 :           // [R10]
    (op_kind == BTAE_OP_CLEAN) ? BTAE_TC_000 :           // [R11]
    (op_kind == BTAE_OP_PUSH_RD) ? BTAE_TC_010 :         // [R13]
    (op_kind == BTAE_OP_PUSH_KILL) ? BTAE_TC_100 :       // [R18]
    BTAE_TC_000;
endmodule

/* File: core/btae_encoder.sv */
/*
  Transfer-attribute encoder of the processor bus master: drives burst
  indicator, transfer code, write-through level and transfer size with
  the address tenure, and re-presents retried copy-back entries.
  Assumes a system bus party that samples attributes with the address
  and may retry a tenure with address_retry one cycle after its start.
*/
`timescale 1ns/1ps

// Summary of operation
// R1: burst indicator asserted for whole burst, negated otherwise.
// R2: control word access drives access register bit 28 on burst pin.
// R3: control word access drives access register bits 29-31 on size.
// R4: in I/O protocol the burst pin is an input sampled as code bit.
// R5: attributes driven and released together with the address bus.
// R6: three-bit transfer code qualifies each transaction with write-through.
// R7: write-through value is the raw pin level, active low.
// R8: first copy-back write goes out ambiguous, write-through low, code xx0.
// R9: outside party retries the ambiguous write to resolve it.
// R10: after retry, re-present with exact code; only direct push may pass. Code also holds the re-present for a new snoop.
// R11: block clean makes line exclusive on entering copy-back queue.
// R12: queued clean line may become modified or invalid before tenure ends.
// R13: read snoop hit on modified line goes shared, push code 010, bus requested.
// R14: copy-back read push keeps shared copy for clean, else invalid.
// R15: outside party retries copy-back read push to learn line outcome.
// R16: retried copy-back 010 push returns next with flush, clean or cast-out code.
// R17: retried 010 push still coded as read push came from data cache.
// R18: kill-type snoop push uses code 100, bus requested, line invalid.
module btae_encoder
  import btae_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_burst,
  input wire logic req_from_cbb,
  input wire logic [2:0] req_size,
  input wire logic [1:0] req_line_state,
  input wire logic [BTAE_EAR_W-1:0] external_access_reg,
  input wire logic io_protocol,
  input wire logic burst_indicator_in,
  input wire logic address_retry,
  input wire logic tenure_done,
  input wire logic snoop_new,
  input wire logic direct_push_valid,
  input wire logic store_hit,
  input wire logic kill_hit,
  output logic req_ready,
  output logic transfer_start,
  output logic addr_oe,
  output logic burst_indicator,
  output logic burst_indicator_oe,
  output logic [2:0] transfer_code,
  output logic write_through_pin,
  output logic [2:0] transfer_size,
  output logic bus_request,
  output logic io_code_bit,
  output logic [1:0] line_state
);
  // ==========================================================
  // held entry
  btae_state_type state_reg;
  btae_state_type state_next;
  logic [2:0] op_reg;
  logic burst_reg;
  logic cbb_reg;
  logic first_reg;
  logic [2:0] size_reg;
  logic ts_reg;
  logic oe_reg;
  logic bi_reg;
  logic bi_oe_reg;
  logic [2:0] tc_reg;
  logic wt_reg;
  logic [2:0] tsiz_reg;
  logic br_reg;
  logic ready_reg;
  logic io_reg;
  logic cbb_clean_reg;

  wire logic map_wt;
  wire logic [2:0] map_code;
  wire logic take = req_valid && ready_reg;
  // attributes go out on the edge that takes the request, so the
  // first tenure cycle reads the request itself, not the held copy
  wire logic [2:0] op_cur = take ? req_op : op_reg;
  wire logic burst_cur = take ? req_burst : burst_reg;
  wire logic cbb_cur = take ? req_from_cbb : cbb_reg;
  wire logic first_cur = take || first_reg;
  wire logic [2:0] size_cur = take ? req_size : size_reg;
  // a direct data-cache push may overtake a pending re-present
  wire logic take_direct = state_reg == BTAE_ST_REPRESENT &&
    direct_push_valid;                                    // [R10] [R17]
  wire logic is_ecw = op_cur == BTAE_OP_ECW;
  wire logic is_push = op_cur == BTAE_OP_PUSH_RD ||
    op_cur == BTAE_OP_PUSH_KILL;
  wire logic retried = state_reg == BTAE_ST_TENURE && address_retry;
  wire logic finished = state_reg == BTAE_ST_TENURE && tenure_done &&
    !address_retry;
  // copy-back read push resolves to its underlying entry on re-present
  wire logic cbb_push = op_reg == BTAE_OP_PUSH_RD && cbb_reg;

  // ==========================================================
  // code map
  btae_code_map u_map (
    .op_kind(op_cur),
    .from_cbb(cbb_cur),
    .first_try(first_cur),
    .wt_level(map_wt),
    .code(map_code)
  );

  // ==========================================================
  // elaboration checks
  // the id bit and the size field must lie inside the access register
  if (BTAE_EAR_ID_BIT >= BTAE_EAR_W) begin : g_id_range
    $error("access register too narrow for the id bit");
  end
  if (BTAE_EAR_SIZE_LSB + BTAE_SIZE_W > BTAE_EAR_W) begin : g_size_range
    $error("access register too narrow for the size field");
  end
  // resource id is one contiguous field: id bit just above the size
  if (BTAE_EAR_ID_BIT + 1 != BTAE_EAR_SIZE_LSB) begin : g_id_order
    $error("id bit must sit next to the size field");
  end
  // the pins are fixed at three bits each
  if (BTAE_CODE_W != 3 || BTAE_SIZE_W != 3) begin : g_pin_width
    $error("transfer code and size pins must be three bits wide");
  end

  // ==========================================================
  // line tracking
  function automatic logic [1:0] btae_done_state(input logic [2:0] op,
                                                 input logic [1:0] cur);
    case (op)
      BTAE_OP_PUSH_RD: btae_done_state = cbb_push ?
        BTAE_LINE_S : BTAE_LINE_S;                         // [R13] [R14]
      BTAE_OP_CLEAN: btae_done_state = cur;                // [R12]
      BTAE_OP_NORMAL,
      BTAE_OP_ECW: btae_done_state = cur;
      default: btae_done_state = BTAE_LINE_I;             // [R14] [R18]
    endcase
  endfunction

  // clean goes exclusive, read push of a modified line shared, on entering the queue
  wire logic [1:0] load_state =
    (req_op == BTAE_OP_CLEAN) ? BTAE_LINE_E :              // [R11]
    (req_op == BTAE_OP_PUSH_RD &&
     req_line_state == BTAE_LINE_M) ? BTAE_LINE_S :        // [R13]
    (req_op == BTAE_OP_PUSH_KILL) ? BTAE_LINE_I :          // [R18]
    req_line_state;
  wire logic [1:0] push_done = (cbb_reg && op_reg == BTAE_OP_PUSH_RD) ?
    (cbb_clean_reg ? BTAE_LINE_S : BTAE_LINE_I) :         // [R14]
    btae_done_state(op_reg, line_state);

  btae_line_track u_line (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(take),
    .load_state(load_state),
    .store_hit(store_hit && op_reg == BTAE_OP_CLEAN),
    .kill_hit(kill_hit),
    .done(finished),
    .done_state(push_done),
    .line_state(line_state)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BTAE_ST_IDLE: if (take) state_next = BTAE_ST_TENURE;
      BTAE_ST_TENURE: begin
        if (retried) begin
          state_next = BTAE_ST_REPRESENT;
        end else if (tenure_done) begin
          state_next = BTAE_ST_IDLE;
        end
      end
      // re-present at once unless a new snoop or a direct data-cache push goes first
      // a new snoop or a direct data-cache push may go ahead of the re-present
      BTAE_ST_REPRESENT: begin
        if (!snoop_new && !direct_push_valid) begin
          state_next = BTAE_ST_TENURE;                     // [R10] [R16]
        end
      end
      default: state_next = BTAE_ST_IDLE;
    endcase
  end

  wire logic start_now = take ||
    (state_reg == BTAE_ST_REPRESENT && !snoop_new &&
     !direct_push_valid);
  // address and attributes share one enable so they release together
  wire logic oe_next = state_next == BTAE_ST_TENURE;      // [R5]

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= BTAE_ST_IDLE;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next == BTAE_ST_IDLE;
    end
  end

  // a copy-back entry whose line is still cached can only be a clean;
  // after a flush or cast-out the cache no longer holds the line
  wire logic cbb_was_clean = req_op == BTAE_OP_CLEAN ||
    (req_from_cbb && req_line_state != BTAE_LINE_I);

  // fields that only a new request changes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_reg <= 1'b0;
      cbb_reg <= 1'b0;
      cbb_clean_reg <= 1'b0;
      size_reg <= BTAE_SIZE_RST;
    end else if (take) begin
      burst_reg <= req_burst;
      cbb_reg <= req_from_cbb;
      cbb_clean_reg <= cbb_was_clean;                      // [R14]
      size_reg <= req_size;
    end
  end

  // a retry turns the entry into its resolved form
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_reg <= BTAE_OP_NORMAL;
      first_reg <= 1'b1;
    end else if (take) begin
      op_reg <= req_op;
      first_reg <= 1'b1;
    end else if (retried) begin
      first_reg <= 1'b0;                                   // [R10]
      if (cbb_push) begin
        op_reg <= cbb_clean_reg ? BTAE_OP_CLEAN :
          BTAE_OP_FLUSH;                                   // [R16]
      end
    end
  end

  // ==========================================================
  // pin drivers
  wire logic [2:0] size_out = is_ecw ?
    external_access_reg[BTAE_EAR_W-1-BTAE_EAR_SIZE_LSB -: 3] :  // [R3]
    size_cur;
  // ear bit 28 in big-endian numbering is vector bit 31-28
  wire logic bi_out = is_ecw ?
    external_access_reg[BTAE_EAR_W-1-BTAE_EAR_ID_BIT] :   // [R2]
    burst_cur;                                           // [R1]

  // tenure framing; no start while a direct push owns the bus
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ts_reg <= 1'b0;
      oe_reg <= 1'b0;
      bi_oe_reg <= 1'b0;
      br_reg <= 1'b0;
    end else begin
      ts_reg <= start_now && !take_direct;
      oe_reg <= oe_next;                                   // [R5]
      bi_oe_reg <= oe_next && !io_protocol;                // [R4] [R5]
      br_reg <= (oe_next && is_push) || take_direct;       // [R13] [R18]
    end
  end

  // attributes sit at their idle values outside a tenure
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bi_reg <= 1'b0;
      tc_reg <= BTAE_TC_RST;
      wt_reg <= 1'b1;
      tsiz_reg <= BTAE_SIZE_RST;
    end else begin
      bi_reg <= oe_next && bi_out;                         // [R1]
      tc_reg <= oe_next ? map_code : BTAE_TC_RST;          // [R5] [R6]
      wt_reg <= oe_next ? map_wt : 1'b1;                   // [R7]
      tsiz_reg <= oe_next ? size_out : BTAE_SIZE_RST;
    end
  end

  // burst pin read back as a code bit under the I/O protocol
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_reg <= 1'b0;
    end else begin
      io_reg <= burst_indicator_in;                        // [R4]
    end
  end

  assign req_ready = ready_reg;
  assign transfer_start = ts_reg;
  assign addr_oe = oe_reg;
  assign burst_indicator = bi_reg;
  assign burst_indicator_oe = bi_oe_reg;
  assign transfer_code = tc_reg;
  assign write_through_pin = wt_reg;
  assign transfer_size = tsiz_reg;
  assign bus_request = br_reg;
  assign io_code_bit = io_reg;
endmodule

/* File: core/btae_line_track.sv */
/*
  Cache-line state tracker for the single line held by the pending
  copy-back or snoop push entry. Assumes one entry is tracked at a time.
*/
`timescale 1ns/1ps
module btae_line_track
  import btae_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [1:0] load_state,
  input wire logic store_hit,
  input wire logic kill_hit,
  input wire logic done,
  input wire logic [1:0] done_state,
  output logic [1:0] line_state
);
  logic [1:0] line_reg;
  logic [1:0] line_next;

  // priority: queue entry, then completion, then later kill, then store
  assign line_next = load ? load_state :
    done ? done_state :
    kill_hit ? BTAE_LINE_I :                             // [R12]
    (store_hit && line_reg != BTAE_LINE_I) ? BTAE_LINE_M :  // [R12]
    line_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_reg <= BTAE_LINE_I;
    end else begin
      line_reg <= line_next;
    end
  end

  assign line_state = line_reg;
endmodule

/* File: core/btae_pkg.sv */
/*
  Package for the transfer-attribute encoder: line states, operation
  kinds, transfer codes and the address-retry re-present machine states.
  Assumes a single core clock domain.
*/
package btae_pkg;
  localparam int BTAE_CODE_W = 3;
  localparam int BTAE_SIZE_W = 3;
  localparam int BTAE_EAR_W = 32;
  // external access register bit positions for the resource identifier
  localparam int BTAE_EAR_ID_BIT = 28;
  localparam int BTAE_EAR_SIZE_LSB = 29;
  // transfer codes (bit 0 of the bus is the leftmost printed bit)
  localparam logic [2:0] BTAE_TC_000 = 3'h0;
  localparam logic [2:0] BTAE_TC_010 = 3'h2;
  localparam logic [2:0] BTAE_TC_100 = 3'h4;
  localparam logic [2:0] BTAE_TC_RST = 3'h0;
  localparam logic [2:0] BTAE_SIZE_RST = 3'h0;
  // cache line states
  localparam logic [1:0] BTAE_LINE_I = 2'h0;
  localparam logic [1:0] BTAE_LINE_S = 2'h1;
  localparam logic [1:0] BTAE_LINE_E = 2'h2;
  localparam logic [1:0] BTAE_LINE_M = 2'h3;
  // operation kinds offered by the cache side
  localparam logic [2:0] BTAE_OP_NORMAL = 3'h0;
  localparam logic [2:0] BTAE_OP_CASTOUT = 3'h1;
  localparam logic [2:0] BTAE_OP_CLEAN = 3'h2;
  localparam logic [2:0] BTAE_OP_FLUSH = 3'h3;
  localparam logic [2:0] BTAE_OP_PUSH_RD = 3'h4;
  localparam logic [2:0] BTAE_OP_PUSH_KILL = 3'h5;
  localparam logic [2:0] BTAE_OP_ECW = 3'h6;

  typedef enum logic [2:0] {
    BTAE_ST_IDLE = 3'h1,
    BTAE_ST_TENURE = 3'h2,
    BTAE_ST_REPRESENT = 3'h4
  } btae_state_type;
endpackage

/* File: sim/btae_bus_party.sv */
/*
  System bus party: ends each tenure promptly or slowly and, when asked,
  retries every tenure once. Assumes retry one cycle after the start.
*/
`timescale 1ns/1ps
module btae_bus_party (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic transfer_start,
  input wire logic retry_en,
  input wire logic slow,
  output logic address_retry,
  output logic tenure_done
);
  // ==========================================
  // tenure ending
  logic retried_reg;
  logic busy_reg;
  logic [2:0] wait_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      address_retry <= 1'b0;
      tenure_done <= 1'b0;
      retried_reg <= 1'b0;
      busy_reg <= 1'b0;
      wait_reg <= 3'h0;
    end else begin
      address_retry <= 1'b0;
      tenure_done <= 1'b0;
      if (transfer_start && retry_en && !retried_reg) begin
        address_retry <= 1'b1;
        retried_reg <= 1'b1;
      end else if (transfer_start) begin
        busy_reg <= 1'b1;
        wait_reg <= slow ? 3'h4 : 3'h0;
      end else if (busy_reg && wait_reg == 3'h0) begin
        tenure_done <= 1'b1;
        busy_reg <= 1'b0;
        retried_reg <= 1'b0;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 3'h1;
      end
    end
  end
endmodule

/* File: sim/btae_encoder_asserts.sv */
/*
  Checker for the transfer-attribute encoder, bound to its top module.
  Assumes one core clock domain and the encoder's port names.
*/
`timescale 1ns/1ps
module btae_encoder_asserts
  import btae_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic req_burst,
  input wire logic req_from_cbb,
  input wire logic [BTAE_EAR_W-1:0] external_access_reg,
  input wire logic io_protocol,
  input wire logic burst_indicator_in,
  input wire logic address_retry,
  input wire logic snoop_new,
  input wire logic direct_push_valid,
  input wire logic transfer_start,
  input wire logic addr_oe,
  input wire logic burst_indicator,
  input wire logic burst_indicator_oe,
  input wire logic [2:0] transfer_code,
  input wire logic write_through_pin,
  input wire logic [2:0] transfer_size,
  input wire logic bus_request,
  input wire logic io_code_bit
);
  // ==========================================
  // checks
  logic tk;
  logic cbb_wr;
  assign tk = req_valid && req_ready;
  assign cbb_wr = req_from_cbb && (req_op == BTAE_OP_CASTOUT ||
    req_op == BTAE_OP_CLEAN || req_op == BTAE_OP_FLUSH);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_burst;
    tk && req_op != BTAE_OP_ECW |=> transfer_start && addr_oe &&
      burst_indicator == $past(req_burst);
  endproperty
  a_burst: assert property (p_burst) else $error("burst wrong");
  property p_ecw_id;
    tk && req_op == BTAE_OP_ECW |=>
      burst_indicator == $past(external_access_reg[3]);
  endproperty
  a_ecw_id: assert property (p_ecw_id) else $error("id bit");
  property p_ecw_size;
    tk && req_op == BTAE_OP_ECW |=>
      transfer_size == $past(external_access_reg[2:0]);
  endproperty
  a_ecw_size: assert property (p_ecw_size) else $error("id size");
  property p_io;
    io_protocol && $past(io_protocol) |->
      !burst_indicator_oe && io_code_bit == $past(burst_indicator_in);
  endproperty
  a_io: assert property (p_io) else $error("io code bit");
  property p_oe;
    !addr_oe |-> !burst_indicator_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("burst oe");
  property p_hold;
    addr_oe && $past(addr_oe) && !$past(address_retry) |->
      $stable(transfer_code) && $stable(write_through_pin);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved");
  property p_ambig;
    tk && cbb_wr |=> !write_through_pin && transfer_code == BTAE_TC_000;
  endproperty
  a_ambig: assert property (p_ambig) else $error("ambiguous form");
  property p_retry;
    address_retry ##1 (!snoop_new && !direct_push_valid) |->
      !addr_oe ##1 transfer_start;
  endproperty
  a_retry: assert property (p_retry) else $error("no re-present");
  property p_push_rd;
    tk && req_op == BTAE_OP_PUSH_RD |=> transfer_code == BTAE_TC_010 &&
      !write_through_pin && bus_request;
  endproperty
  a_push_rd: assert property (p_push_rd) else $error("read push");
  property p_kill;
    tk && req_op == BTAE_OP_PUSH_KILL |=> transfer_code == BTAE_TC_100 &&
      !write_through_pin && bus_request;
  endproperty
  a_kill: assert property (p_kill) else $error("kill push");
endmodule

bind btae_encoder btae_encoder_asserts chk (.core_clk(core_clk),
  .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
  .req_op(req_op), .req_burst(req_burst), .req_from_cbb(req_from_cbb),
  .external_access_reg(external_access_reg), .io_protocol(io_protocol),
  .burst_indicator_in(burst_indicator_in), .snoop_new(snoop_new),
  .direct_push_valid(direct_push_valid),
  .address_retry(address_retry), .transfer_start(transfer_start),
  .addr_oe(addr_oe), .burst_indicator(burst_indicator),
  .burst_indicator_oe(burst_indicator_oe), .transfer_code(transfer_code),
  .write_through_pin(write_through_pin), .transfer_size(transfer_size),
  .bus_request(bus_request), .io_code_bit(io_code_bit));

/* File: sim/btae_encoder_tb.sv */
/*
  Testbench for the transfer-attribute encoder with a bus party model.
  Assumes the encoder answers a taken request on the next cycle.
*/
`timescale 1ns/1ps
module btae_encoder_tb
  import btae_pkg::*;
;
  logic core_clk, arst_n, req_valid, req_burst, req_from_cbb, io_protocol;
  logic burst_indicator_in, store_hit, kill_hit, retry_en, slow;
  logic [2:0] req_op, req_size, transfer_code, transfer_size;
  logic [1:0] req_line_state, line_state;
  logic [31:0] external_access_reg;
  logic address_retry, tenure_done, req_ready, transfer_start, addr_oe;
  logic burst_indicator, burst_indicator_oe, write_through_pin;
  logic bus_request, io_code_bit, snoop_new, direct_push_valid;
  int n_errors = 0;
  int comparisons = 0;
  btae_encoder dut (.core_clk(core_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_op(req_op), .req_burst(req_burst),
    .req_from_cbb(req_from_cbb), .req_size(req_size),
    .req_line_state(req_line_state),
    .external_access_reg(external_access_reg), .io_protocol(io_protocol),
    .burst_indicator_in(burst_indicator_in), .address_retry(address_retry),
    .tenure_done(tenure_done), .snoop_new(snoop_new),
    .direct_push_valid(direct_push_valid),
    .store_hit(store_hit), .kill_hit(kill_hit), .req_ready(req_ready),
    .transfer_start(transfer_start), .addr_oe(addr_oe),
    .burst_indicator(burst_indicator),
    .burst_indicator_oe(burst_indicator_oe), .transfer_code(transfer_code),
    .write_through_pin(write_through_pin), .transfer_size(transfer_size),
    .bus_request(bus_request), .io_code_bit(io_code_bit),
    .line_state(line_state));
  btae_bus_party party (.core_clk(core_clk), .arst_n(arst_n),
    .transfer_start(transfer_start), .retry_en(retry_en), .slow(slow),
    .address_retry(address_retry), .tenure_done(tenure_done));
  // ==========================================
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic send(logic [2:0] op, logic b, logic cbb);
    int i = 0;
    req_op = op;
    req_burst = b;
    req_from_cbb = cbb;
    while (req_ready !== 1'b1 && i < 50) begin step(1); i++; end
    if (i == 50) n_errors++;
    req_valid = 1'b1;
    step(1);
    req_valid = 1'b0;
  endtask
  task automatic wait_ts();
    int i = 0;
    while (transfer_start !== 1'b1 && i < 40) begin step(1); i++; end
    if (i == 40) n_errors++;
  endtask
  task automatic wait_idle();
    int i = 0;
    step(1);
    while (req_ready !== 1'b1 && i < 40) begin step(1); i++; end
    if (i == 40) n_errors++;
  endtask
  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_basic();
    send(BTAE_OP_NORMAL, 1'b1, 1'b0);
    chk("start", 1, transfer_start);
    chk("burst", 1, burst_indicator);
    chk("oe", 1, addr_oe);
    chk("bi_oe", 1, burst_indicator_oe);
    chk("size", 2, transfer_size);
    chk("busy", 0, req_ready);
    wait_idle();
    chk("oe_off", 0, addr_oe);
    chk("bi_oe_off", 0, burst_indicator_oe);
    chk("code_off", BTAE_TC_RST, transfer_code);
    send(BTAE_OP_NORMAL, 1'b0, 1'b0);
    chk("single", 0, burst_indicator);
    wait_idle();
  endtask
  task automatic t_ecw();
    external_access_reg = 32'h0000000B;
    send(BTAE_OP_ECW, 1'b0, 1'b0);
    chk("ecw_id", 1, burst_indicator);
    chk("ecw_size", 3, transfer_size);
    wait_idle();
    external_access_reg = 32'hFFFFFFF4;
    send(BTAE_OP_ECW, 1'b1, 1'b0);
    chk("ecw_id", 0, burst_indicator);
    chk("ecw_size", 4, transfer_size);
    wait_idle();
  endtask
  task automatic t_ambig();
    logic [2:0] ops [3] = '{BTAE_OP_CASTOUT, BTAE_OP_CLEAN, BTAE_OP_FLUSH};
    logic [2:0] tcs [3] = '{BTAE_TC_100, BTAE_TC_000, BTAE_TC_100};
    logic wts [3] = '{1'b1, 1'b0, 1'b0};
    retry_en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      slow = k[0];
      send(ops[k], 1'b1, 1'b1);
      chk("amb_wt", 0, write_through_pin);
      chk("amb_tc", 0, transfer_code);
      step(1);
      wait_ts();
      chk("res_wt", wts[k], write_through_pin);
      chk("res_tc", tcs[k], transfer_code);
      wait_idle();
    end
  endtask
  task automatic t_push();
    send(BTAE_OP_PUSH_RD, 1'b1, 1'b1);
    chk("prd_tc", BTAE_TC_010, transfer_code);
    chk("prd_br", 1, bus_request);
    step(1);
    wait_ts();
    chk("prd_back", BTAE_TC_000, transfer_code);
    chk("prd_bwt", 0, write_through_pin);
    wait_idle();
    chk("prd_keep", BTAE_LINE_S, line_state);
    send(BTAE_OP_PUSH_RD, 1'b1, 1'b0);
    step(1);
    chk("prd_line", BTAE_LINE_S, line_state);
    wait_ts();
    chk("direct", BTAE_TC_010, transfer_code);
    wait_idle();
    retry_en = 1'b0;
    send(BTAE_OP_PUSH_KILL, 1'b1, 1'b0);
    chk("kill_tc", BTAE_TC_100, transfer_code);
    chk("kill_br", 1, bus_request);
    wait_idle();
    chk("kill_line", BTAE_LINE_I, line_state);
  endtask
  task automatic t_hold();
    retry_en = 1'b1;
    send(BTAE_OP_CASTOUT, 1'b1, 1'b1);
    snoop_new = 1'b1;
    step(4);
    chk("held_ts", 0, transfer_start);
    chk("held_oe", 0, addr_oe);
    snoop_new = 1'b0;
    direct_push_valid = 1'b1;
    step(2);
    chk("pass_ts", 0, transfer_start);
    direct_push_valid = 1'b0;
    step(1);
    chk("back_ts", 1, transfer_start);
    chk("back_tc", BTAE_TC_100, transfer_code);
    chk("back_wt", 1, write_through_pin);
    wait_idle();
  endtask
  task automatic t_line();
    slow = 1'b1;
    send(BTAE_OP_CLEAN, 1'b1, 1'b1);
    step(1);
    chk("clean_e", BTAE_LINE_E, line_state);
    store_hit = 1'b1;
    step(1);
    store_hit = 1'b0;
    chk("store_m", BTAE_LINE_M, line_state);
    kill_hit = 1'b1;
    step(1);
    kill_hit = 1'b0;
    chk("kill_i", BTAE_LINE_I, line_state);
    wait_idle();
    slow = 1'b0;
  endtask
  task automatic t_io();
    io_protocol = 1'b1;
    burst_indicator_in = 1'b1;
    step(2);
    chk("io_bit", 1, io_code_bit);
    chk("io_oe", 0, burst_indicator_oe);
    burst_indicator_in = 1'b0;
    step(1);
    chk("io_bit", 0, io_code_bit);
    send(BTAE_OP_NORMAL, 1'b1, 1'b0);
    chk("io_oe_t", 0, burst_indicator_oe);
    chk("io_aoe", 1, addr_oe);
    wait_idle();
    io_protocol = 1'b0;
  endtask
  // ==========================================
  // run
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    n_errors++;
    results();
  end
  initial begin
    {arst_n, req_valid, req_burst, req_from_cbb, io_protocol} = '0;
    {burst_indicator_in, store_hit, kill_hit, retry_en, slow} = '0;
    {snoop_new, direct_push_valid} = '0;
    req_op = BTAE_OP_NORMAL;
    req_size = 3'h2;
    req_line_state = BTAE_LINE_M;
    external_access_reg = 32'h0;
    step(4);
    arst_n = 1'b1;
    t_basic();
    t_ecw();
    t_ambig();
    t_hold();
    t_push();
    t_line();
    t_io();
    results();
  end
endmodule
